/* design/sssi_pkg.sv */
package sssi_pkg;
  localparam logic [5:0] I2C_ACCEL_BASE = 6'h0c;
  localparam logic [5:0] I2C_GYRO_BASE  = 6'h34;
  localparam logic [4:0] I2C_MAG_BASE   = 5'h04;
  localparam logic [2:0] BANK_ACCEL     = 3'h1;
  localparam logic [2:0] BANK_GYRO      = 3'h2;
  localparam logic [2:0] BANK_MAGNET    = 3'h4;
  localparam logic [3:0] CTRL_LAST_BIT  = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam logic [3:0] DATA_FIRST_BIT = 4'h8;
  localparam logic [3:0] I2C_ACK_SLOT   = 4'h8;
  localparam logic [6:0] ADDR_RESET     = 7'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam int         SYNC_WIDTH     = 9;
  // Idle pin levels after reset: all three selects high, every other bit low.
  localparam logic [SYNC_WIDTH-1:0] SYNC_IDLE = 9'h01c;

  typedef enum logic [5:0] {
    ST_IDLE      = 6'b000001,
    ST_SPI       = 6'b000010,
    ST_I2C_ADDR  = 6'b000100,
    ST_I2C_REG   = 6'b001000,
    ST_I2C_WDATA = 6'b010000,
    ST_I2C_RDATA = 6'b100000
  } sssi_state_t;
endpackage

/* design/sssi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sssi_sync #(
  parameter int               WIDTH      = 1,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rstLocal_n,
  // Levels.
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // Reset holds the pins' idle levels, so no false select edge follows reset.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      stage1 <= IDLE_LEVEL;
      dout   <= IDLE_LEVEL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // sssi_sync
`default_nettype wire

/* design/sssi_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sssi_top import sssi_pkg::*; (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Straps.
  input  wire logic       protocol_select_strap,
  input  wire logic       first_addr_strap,
  input  wire logic       second_addr_strap,
  input  wire logic       magnet_addr_bit1_strap,
  // Chip selects and serial clock.
  input  wire logic       accel_chip_select_low,
  input  wire logic       gyro_chip_select_low,
  input  wire logic       magnet_chip_select_low,
  input  wire logic       shared_clock_pin,
  // Shared data pin.
  input  wire logic       shared_data_pin_in,
  output logic            shared_data_pin_out,
  output logic            shared_data_pin_oe_n,
  // Serial data outputs.
  output logic            accel_magnet_serial_out,
  output logic            accel_magnet_serial_out_oe_n,
  output logic            gyro_serial_out,
  output logic            gyro_serial_out_oe_n,
  // Configuration and status.
  input  wire logic       threeWireAccel,
  input  wire logic       threeWireGyro,
  output logic            spiThreeWire,
  output logic            spiModeHigh,
  // Register access.
  output logic      [2:0] regBank,
  output logic      [6:0] regAddr,
  output logic            wrStrobe,
  output logic      [7:0] wrData,
  output logic            rdStrobe,
  input  wire logic [7:0] rdData
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]              rstSync;
  wire                     rstLocal_n = rstSync[1];
  logic [SYNC_WIDTH-1:0]   syncd;
  sssi_state_t             state;
  logic                    sclPrev;
  logic                    sdaPrev;
  logic [3:0]              bitCnt;
  logic [7:0]              shiftIn;
  logic [7:0]              txShift;
  logic                    txBit;
  logic                    rw;
  logic                    rdPend;

  // Reset is released through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // Every strap, select, clock and data pin passes two flip-flops before any logic looks at it; the three-wire inputs do not.
  sssi_sync #(.WIDTH(SYNC_WIDTH), .IDLE_LEVEL(SYNC_IDLE)) uSync (
    .sys_clk    (sys_clk),
    .rstLocal_n (rstLocal_n),
    .din        ({protocol_select_strap, first_addr_strap, second_addr_strap,
                  magnet_addr_bit1_strap, accel_chip_select_low,
                  gyro_chip_select_low, magnet_chip_select_low,
                  shared_clock_pin, shared_data_pin_in}),
    .dout       (syncd)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire       psI2c   = syncd[8];
  wire       strap1  = syncd[7];
  wire       strap2  = syncd[6];
  wire       strapM  = syncd[5];
  wire [2:0] csLow   = ~{syncd[2], syncd[3], syncd[4]};
  wire       scl     = syncd[1];
  wire       sda     = syncd[0];
  wire       sclRise = scl & ~sclPrev;
  wire       sclFall = ~scl & sclPrev;
  wire       i2cStart = psI2c & scl & sclPrev & sdaPrev & ~sda;
  wire       i2cStop  = psI2c & scl & sclPrev & ~sdaPrev & sda;
  // A select is honoured only with the strap low.
  wire       csAny   = ~psI2c & (csLow != 3'h0);
  wire       csOwn   = ~psI2c & ((csLow & regBank) != 3'h0);
  wire [2:0] bankSel = csLow[0] ? BANK_ACCEL : (csLow[1] ? BANK_GYRO : BANK_MAGNET);
  wire [7:0] shiftNext = {shiftIn[6:0], sda};
  wire [3:0] cntNext   = (bitCnt == FRAME_LAST_BIT) ? DATA_FIRST_BIT : bitCnt + 4'h1;
  // Only 7-bit addresses are decoded; 10-bit headers never match.
  wire hitAcc  = shiftIn[7:1] == {I2C_ACCEL_BASE, strap1};
  wire hitGyro = shiftIn[7:1] == {I2C_GYRO_BASE, strap2};
  wire hitMag  = shiftIn[7:1] == {I2C_MAG_BASE, strapM, strap1};
  wire addrHit = hitAcc | hitGyro | hitMag;
  wire [2:0] hitBank = hitAcc ? BANK_ACCEL : (hitGyro ? BANK_GYRO : BANK_MAGNET);
  wire spiDriveSlot = sclFall & rw & (bitCnt >= DATA_FIRST_BIT);

  assign spiThreeWire            = threeWireAccel & threeWireGyro;
  assign shared_data_pin_out     = txBit;
  assign accel_magnet_serial_out = txBit;
  assign gyro_serial_out         = txBit;

  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      sclPrev <= 1'b0;
      sdaPrev <= 1'b0;
      rdPend  <= 1'b0;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sda;
      rdPend  <= rdStrobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The fetched byte lands two cycles after the strobe, well before the next
  // falling clock edge, since a serial half period spans at least four cycles.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      state                        <= ST_IDLE;
      bitCnt                       <= 4'h0;
      shiftIn                      <= BYTE_RESET;
      txShift                      <= BYTE_RESET;
      txBit                        <= 1'b0;
      rw                           <= 1'b0;
      spiModeHigh                  <= 1'b0;
      regBank                      <= BANK_ACCEL;
      regAddr                      <= ADDR_RESET;
      wrStrobe                     <= 1'b0;
      wrData                       <= BYTE_RESET;
      rdStrobe                     <= 1'b0;
      shared_data_pin_oe_n         <= 1'b1;
      accel_magnet_serial_out_oe_n <= 1'b1;
      gyro_serial_out_oe_n         <= 1'b1;
    end else begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      case (state)
        ST_IDLE: begin
          bitCnt                       <= 4'h0;
          rw                           <= 1'b0;
          shared_data_pin_oe_n         <= 1'b1;
          accel_magnet_serial_out_oe_n <= 1'b1;
          gyro_serial_out_oe_n         <= 1'b1;
          if (csAny) begin
            state       <= ST_SPI;
            regBank     <= bankSel;
            spiModeHigh <= scl;
          end else if (i2cStart) begin
            state <= ST_I2C_ADDR;
          end
        end
        ST_SPI: begin
          if (!csOwn) begin
            state <= ST_IDLE;
            shared_data_pin_oe_n         <= 1'b1;
            accel_magnet_serial_out_oe_n <= 1'b1;
            gyro_serial_out_oe_n         <= 1'b1;
          end else if (sclRise) begin
            shiftIn <= shiftNext;
            bitCnt  <= cntNext;
            if (bitCnt == CTRL_LAST_BIT) begin
              rw       <= shiftNext[7];
              regAddr  <= shiftNext[6:0];
              rdStrobe <= shiftNext[7];
            end
            if (bitCnt == FRAME_LAST_BIT) begin
              if (rw) begin
                regAddr  <= regAddr + 7'h1;
                rdStrobe <= 1'b1;
              end else begin
                wrData   <= shiftNext;
                wrStrobe <= 1'b1;
              end
            end
          end else if (spiDriveSlot) begin
            txBit   <= txShift[7];
            txShift <= {txShift[6:0], 1'b0};
            if (spiThreeWire) begin
              shared_data_pin_oe_n <= 1'b0;
            end else if (regBank == BANK_GYRO) begin
              gyro_serial_out_oe_n <= 1'b0;
            end else begin
              accel_magnet_serial_out_oe_n <= 1'b0;
            end
          end
        end
        default: begin
          if (i2cStop || !psI2c) begin
            state                <= ST_IDLE;
            shared_data_pin_oe_n <= 1'b1;
          end else if (i2cStart) begin
            state                <= ST_I2C_ADDR;
            bitCnt               <= 4'h0;
            shared_data_pin_oe_n <= 1'b1;
          end else if (sclRise) begin
            bitCnt <= (bitCnt == I2C_ACK_SLOT) ? 4'h0 : bitCnt + 4'h1;
            if (bitCnt != I2C_ACK_SLOT) begin
              shiftIn <= shiftNext;
            end else if (state == ST_I2C_RDATA && sda) begin
              state <= ST_IDLE;
            end
          end else if (sclFall) begin
            txBit <= 1'b0;
            if (bitCnt == I2C_ACK_SLOT) begin
              shared_data_pin_oe_n <= 1'b1;
              case (state)
                ST_I2C_ADDR: begin
                  if (addrHit) begin
                    shared_data_pin_oe_n <= 1'b0;
                    regBank              <= hitBank;
                    rdStrobe             <= shiftIn[0];
                    state <= shiftIn[0] ? ST_I2C_RDATA : ST_I2C_REG;
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                ST_I2C_REG: begin
                  regAddr              <= shiftIn[6:0];
                  shared_data_pin_oe_n <= 1'b0;
                  state                <= ST_I2C_WDATA;
                end
                ST_I2C_WDATA: begin
                  wrData               <= shiftIn;
                  wrStrobe             <= 1'b1;
                  shared_data_pin_oe_n <= 1'b0;
                end
                default: begin
                  regAddr  <= regAddr + 7'h1;
                  rdStrobe <= 1'b1;
                end
              endcase
            end else if (state == ST_I2C_RDATA) begin
              shared_data_pin_oe_n <= txShift[7];
              txShift              <= {txShift[6:0], 1'b0};
            end else begin
              shared_data_pin_oe_n <= 1'b1;
            end
          end
        end
      endcase
      if (rdPend) begin
        txShift <= rdData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstLocal_n);

  a_strap_spi_entry: assert property ($rose(state == ST_SPI) |-> $past(!psI2c))
    else $error("SPI entered with I2C strap");
  a_mode_capture: assert property ((state == ST_IDLE && csAny) |=> spiModeHigh == $past(scl))
    else $error("SPI mode not taken from clock level");
  a_three_wire_pin: assert property ((state == ST_SPI && !shared_data_pin_oe_n) |-> spiThreeWire)
    else $error("Shared pin driven in 4-wire SPI");
  a_write_quiet: assert property ((state == ST_SPI && !rw)
      |-> accel_magnet_serial_out_oe_n && gyro_serial_out_oe_n && shared_data_pin_oe_n)
    else $error("Data output driven during SPI write");
  a_read_fetch: assert property ((state == ST_SPI && csOwn && sclRise
      && bitCnt == CTRL_LAST_BIT && shiftNext[7]) |=> rdStrobe && regAddr == $past(shiftNext[6:0]))
    else $error("Read command did not fetch its address");
  a_write_frame: assert property ((state == ST_SPI && csOwn && sclRise
      && bitCnt == FRAME_LAST_BIT && !rw) |=> wrStrobe && wrData == $past(shiftNext) ##1 !wrStrobe)
    else $error("Write frame did not deliver its byte");
  a_burst_incr: assert property ((state == ST_SPI && csOwn && sclRise
      && bitCnt == FRAME_LAST_BIT && rw) |=> rdStrobe && regAddr == 7'($past(regAddr) + 7'h1))
    else $error("Burst read did not advance address");
  a_i2c_ack_hit: assert property ((state == ST_I2C_ADDR && psI2c
      && !i2cStop && !i2cStart && sclFall && bitCnt == I2C_ACK_SLOT && addrHit)
      |=> !shared_data_pin_oe_n && regBank == $past(hitBank))
    else $error("Matching slave address not acknowledged");
  a_i2c_ignore_miss: assert property ((state == ST_I2C_ADDR && !i2cStop
      && !i2cStart && sclFall && bitCnt == I2C_ACK_SLOT && !addrHit)
      |=> state == ST_IDLE && shared_data_pin_oe_n)
    else $error("Foreign slave address acknowledged");
  a_deselect_release: assert property ((state == ST_SPI && !csOwn)
      |=> accel_magnet_serial_out_oe_n && gyro_serial_out_oe_n && shared_data_pin_oe_n)
    else $error("Data line driven after deselect");

  c_spi_burst: cover property (state == ST_SPI && rdStrobe && bitCnt == DATA_FIRST_BIT);
  c_i2c_write: cover property (state == ST_I2C_WDATA && wrStrobe);
  c_three_wire_read: cover property (state == ST_SPI && !shared_data_pin_oe_n);
  c_mode_high: cover property (state == ST_SPI && spiModeHigh);
endmodule // sssi_top
`default_nettype wire

/* verification/sssi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sssi_host_model (
  // Link lines driven by the master.
  output logic       sck,
  output logic [2:0] chipSel_n,
  output logic       hostBit,
  output logic       hostEn,
  // Resolved levels seen by the master.
  input  wire logic  miso,
  input  wire logic  sdaLevel
);
  localparam time HALF = 24ns;

  initial begin
    sck = 1'b1;
    chipSel_n = 3'b111;
    hostBit = 1'b1;
    hostEn = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select framing and clock belong to the master alone.
  task automatic spiXfer(input int sel, input logic cpol, input logic [7:0] ctrl,
                         input logic [7:0] wdat, input int nb, output logic [15:0] rx);
    logic [7:0] tx;
    rx = '0;
    sck = cpol;
    #HALF chipSel_n[sel] = 1'b0;
    #HALF;
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      tx = (i < 8) ? ctrl : wdat;
      sck = 1'b0;
      hostEn = !(ctrl[7] && i >= 8);
      hostBit = tx[7 - i % 8];
      #HALF sck = 1'b1;
      rx = {rx[14:0], miso};
      #HALF;
    end
    sck = cpol;
    #HALF chipSel_n = 3'b111;
    hostEn = 1'b1;
    #(2 * HALF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain signalling: a one on the data line only releases it.
  // Clock goes low first so a slave still acknowledging lets go before a repeated start.
  task automatic i2cStart();
    hostEn = 1'b1;
    sck = 1'b0;
    #(HALF / 2) hostBit = 1'b1;
    #(HALF / 2) sck = 1'b1;
    #HALF hostBit = 1'b0;
    #HALF;
  endtask

  task automatic i2cRead(input logic nack, output logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      sck = 1'b0;
      #(HALF / 2) hostBit = (i < 8) ? 1'b1 : nack;
      #(HALF / 2) sck = 1'b1;
      if (i < 8) b[7 - i] = sdaLevel;
      #HALF;
    end
  endtask

  task automatic i2cByte(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 9; i++) begin
      sck = 1'b0;
      #(HALF / 2) hostBit = (i < 8) ? b[7 - i] : 1'b1;
      #(HALF / 2) sck = 1'b1;
      ack = !sdaLevel;
      #HALF;
    end
  endtask

  task automatic i2cStop();
    sck = 1'b0;
    #(HALF / 2) hostBit = 1'b0;
    #(HALF / 2) sck = 1'b1;
    #HALF hostBit = 1'b1;
    #(2 * HALF);
  endtask
endmodule // sssi_host_model
`default_nettype wire

/* verification/sensor_serial_slave_interface_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_serial_slave_interface_test;
  import sssi_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n, protocolSelectStrap, firstAddrStrap, secondAddrStrap;
  logic       magnetAddrBit1Strap, threeWireAccel, threeWireGyro, idlePat = 1'b0;
  logic       sharedOut, sharedOe_n, amOut, amOe_n, gOut, gOe_n;
  logic       spiThreeWire, spiModeHigh, wrStrobe, rdStrobe, sck, hostBit, hostEn, ack;
  logic [2:0] regBank, chipSel_n;
  logic [6:0] regAddr;
  logic [7:0] wrData, rdData;
  logic [15:0] rx;
  logic [17:0] lastWr;
  wire        sharedLine, miso;
  int         wrCount = 0, driveCount = 0, compares = 0, mismatches = 0, w0, d0;

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] regVal(input logic [2:0] bank, input logic [6:0] addr);
    return {addr, 1'b0} ^ {5'h00, bank};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Released 4-wire outputs show a changing pattern so a stale bit never passes; a released shared line reads high.
  assign sharedLine = (sharedOe_n ? 1'b1 : sharedOut) & (hostEn ? hostBit : 1'b1);
  assign miso = spiThreeWire ? sharedLine : !chipSel_n[1] ? (gOe_n ? idlePat : gOut)
                : (amOe_n ? idlePat : amOut);
  assign rdData = regVal(regBank, regAddr);

  always @(posedge sys_clk) begin
    idlePat <= ~idlePat;
    if (wrStrobe === 1'b1) begin
      wrCount <= wrCount + 1;
      lastWr <= {regBank, regAddr, wrData};
    end
    if (!(amOe_n && gOe_n && sharedOe_n)) driveCount <= driveCount + 1;
  end

  sssi_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .protocol_select_strap(protocolSelectStrap),
    .first_addr_strap(firstAddrStrap), .second_addr_strap(secondAddrStrap),
    .magnet_addr_bit1_strap(magnetAddrBit1Strap), .accel_chip_select_low(chipSel_n[0]),
    .gyro_chip_select_low(chipSel_n[1]), .magnet_chip_select_low(chipSel_n[2]),
    .shared_clock_pin(sck), .shared_data_pin_in(sharedLine), .shared_data_pin_out(sharedOut),
    .shared_data_pin_oe_n(sharedOe_n), .accel_magnet_serial_out(amOut),
    .accel_magnet_serial_out_oe_n(amOe_n), .gyro_serial_out(gOut), .gyro_serial_out_oe_n(gOe_n),
    .threeWireAccel(threeWireAccel), .threeWireGyro(threeWireGyro), .spiThreeWire(spiThreeWire),
    .spiModeHigh(spiModeHigh), .regBank(regBank), .regAddr(regAddr), .wrStrobe(wrStrobe),
    .wrData(wrData), .rdStrobe(rdStrobe), .rdData(rdData));

  sssi_host_model model (.sck(sck), .chipSel_n(chipSel_n), .hostBit(hostBit),
    .hostEn(hostEn), .miso(miso), .sdaLevel(sharedLine));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic i2cWrite(input logic [6:0] dev, input logic [2:0] bank, input logic [7:0] dat);
    logic a0, a1, a2;
    w0 = wrCount;
    model.i2cStart();
    model.i2cByte({dev, 1'b0}, a0);
    model.i2cByte(8'h10, a1);
    model.i2cByte(dat, a2);
    model.i2cStop();
    check({a0, a1, a2}, 3'b111);
    check(wrCount - w0, 1);
    check(lastWr, {bank, 7'h10, dat});
  endtask

  // Register byte, repeated start, then two bytes read, the last one refused.
  task automatic i2cReadBack(input logic [6:0] dev, input logic [2:0] bank, input logic [6:0] adr);
    logic a0, a1, a2;
    logic [7:0] b0, b1;
    model.i2cStart();
    model.i2cByte({dev, 1'b0}, a0);
    model.i2cByte({1'b0, adr}, a1);
    model.i2cStart();
    model.i2cByte({dev, 1'b1}, a2);
    model.i2cRead(1'b0, b0);
    model.i2cRead(1'b1, b1);
    model.i2cStop();
    check({a0, a1, a2}, 3'b111);
    check({b0, b1}, {regVal(bank, adr), regVal(bank, 7'(adr + 7'h1))});
  endtask

  // A header that matches no slave must go unanswered.
  task automatic i2cProbe(input logic [7:0] hdr);
    model.i2cStart();
    model.i2cByte(hdr, ack);
    model.i2cStop();
    check(ack, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {protocolSelectStrap, firstAddrStrap, secondAddrStrap, magnetAddrBit1Strap} = 4'h0;
    {threeWireAccel, threeWireGyro} = 2'b00;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    check({amOe_n, gOe_n, sharedOe_n, regBank, regAddr}, {3'b111, BANK_ACCEL, 7'h00});
    check(spiThreeWire, 1'b0);
    w0 = wrCount;
    d0 = driveCount;
    model.spiXfer(0, 1'b1, 8'h12, 8'ha5, 1, rx);
    check(wrCount - w0, 1);
    check(lastWr, {BANK_ACCEL, 7'h12, 8'ha5});
    check(driveCount - d0, 0);
    check(spiModeHigh, 1'b1);
    model.spiXfer(0, 1'b1, 8'h85, 8'hff, 1, rx);
    check(rx[7:0], regVal(BANK_ACCEL, 7'h05));
    model.spiXfer(1, 1'b0, 8'h82, 8'hff, 3, rx);
    check(spiModeHigh, 1'b0);
    check(rx, {regVal(BANK_GYRO, 7'h03), regVal(BANK_GYRO, 7'h04)});
    @(posedge sys_clk);
    #1 threeWireAccel = 1'b1;
    @(posedge sys_clk);
    check(spiThreeWire, 1'b0);
    #1 threeWireGyro = 1'b1;
    @(posedge sys_clk);
    check(spiThreeWire, 1'b1);
    model.spiXfer(2, 1'b1, 8'hff, 8'hff, 1, rx);
    check(rx[7:0], regVal(BANK_MAGNET, 7'h7f));
    model.spiXfer(0, 1'b0, 8'h21, 8'h5a, 1, rx);
    check(lastWr, {BANK_ACCEL, 7'h21, 8'h5a});
    @(posedge sys_clk);
    #1 {threeWireAccel, threeWireGyro} = 2'b00;
    protocolSelectStrap = 1'b1;
    repeat (6) @(posedge sys_clk);
    w0 = wrCount;
    model.spiXfer(0, 1'b1, 8'h12, 8'h3c, 1, rx);
    check(wrCount - w0, 0);
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      #1 {firstAddrStrap, secondAddrStrap, magnetAddrBit1Strap} = k[2:0];
      repeat (6) @(posedge sys_clk);
      i2cWrite(7'h18 | k[2], BANK_ACCEL, 8'h09);
      i2cWrite(7'h68 | k[1], BANK_GYRO, k[7:0]);
      i2cWrite({5'b00100, k[0], k[2]}, BANK_MAGNET, 8'hc3);
    end
    i2cProbe(8'h34);
    i2cProbe(8'hf0);
    i2cReadBack(7'h69, BANK_GYRO, 7'h22);
    final_report();
  end

  // The sequence needs well under this span; getting here means a hang.
  initial begin
    #200us;
    mismatches++;
    final_report();
  end
endmodule // sensor_serial_slave_interface_test
`default_nettype wire
